// ### src/intc_defines.svh
// register offsets, bit positions and reset values of the interrupt controller
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

`define ADDR_STATUS    6'h00
`define ADDR_CORE      6'h01
`define ADDR_CTRL1     6'h02
`define ADDR_CTRL2     6'h03
`define ADDR_FLAG0     6'h08
`define ADDR_ENABLE0   6'h10
`define ADDR_PRIO0     6'h20
`define PRIO_MISSING   6'h0f

`define LVL_LO_POS     5
`define LVL_HI_POS     3
`define NEST_POS       15
`define TRAP_LSB_POS   1
`define ALT_POS        15
`define DELAYED_DISABLE_ACTIVE_POS       14
`define POL_LSB_POS    0

`define EXT0_SRC       0
`define EXT1_SRC       20
`define EXT2_SRC       29
`define EXT3_SRC       53
`define EXT4_SRC       54

`define FLAG_REGS      5
`define PRIO_REGS      17
`define SRC_PER_PRIO   4
`define EXT_PINS       5
`define RESET_WORD     16'h0000
`define SYNC_FILL      2'h3

`endif

// ### src/intc_pkg.sv
// shared types of the interrupt controller
package intc_pkg;
  typedef logic [2:0] prio_t;
  typedef logic [3:0] level_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_STATUS = 3'b001,
    SEL_CORE   = 3'b010,
    SEL_CTRL1  = 3'b011,
    SEL_CTRL2  = 3'b100,
    SEL_FLAG   = 3'b101,
    SEL_ENABLE = 3'b110,
    SEL_PRIO   = 3'b111
  } reg_sel_t;
endpackage

// ### src/ext_edge_detect.sv
// external interrupt pin synchroniser and polarity edge detector
`timescale 1ns/10ps
`default_nettype none
`include "intc_defines.svh"

module ext_edge_detect #(
  parameter int N = `EXT_PINS
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] polarity,
  output logic      [N-1:0] edge_pulse
);
  import intc_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    logic [N-1:0] pulse;
    logic [1:0]   fill;
  } edge_state_t;

  edge_state_t st;
  edge_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.pulse = '0;
    if (st.fill != `SYNC_FILL) begin
      // pipeline still filling: take the level without an edge
      next_st.fill = st.fill + 2'h1;
      // settle on the second stage so a pin idling high gives no edge
      next_st.lvl = st.s2;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (st.s2[i] == st.s3[i] && st.s3[i] != st.lvl[i]) begin
          next_st.lvl[i] = st.s3[i];
          // one selects the falling edge
          next_st.pulse[i] = polarity[i] ? !st.s3[i] : st.s3[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_pulse = st.pulse;
endmodule
`default_nettype wire

// ### src/interrupt_priority_control.sv
// interrupt controller: flags, enables, priorities, cpu level and arbitration
//
// Contract
// - thirty interrupt registers in the map
// - request flag set by source, software clears
// - per-source enable gates the request
// - three-bit priority per user source; sources 60 to 63 and 68 to 79 have no priority field and stay at zero
// - bit positions follow vector order
// - status word bits 7:5 hold level
// - four-bit level, high bit on top
// - level seven blocks every user interrupt
// - high bit set blocks peripheral interrupts
// - software cannot set the high bit
// - nesting disable locks status level bits
// - control one bit 15 disables nesting
// - control one bits 4:1 trap flags
// - control two bit 15 selects alternate table
// - control two bit 14 mirrors delayed disable
// - control two bits 4:0 edge polarity
// - unimplemented bits read zero, ignore writes
// - equal priority: lower vector number wins
`timescale 1ns/10ps
`default_nettype none
`include "intc_defines.svh"

module interrupt_priority_control #(
  parameter int FLAG_REGS = `FLAG_REGS,
  parameter int PRIO_REGS = `PRIO_REGS
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic [5:0]                reg_addr,
  input  wire intc_pkg::word_t           reg_wr_data,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output intc_pkg::word_t                reg_rd_data,
  input  wire logic [FLAG_REGS*16-1:0]   src_request,
  input  wire logic [`EXT_PINS-1:0]      ext_pin,
  input  wire logic                      trap_arith,
  input  wire logic                      trap_address,
  input  wire logic                      trap_stack,
  input  wire logic                      trap_osc,
  input  wire logic                      core_level_set,
  input  wire logic                      cpu_level_load,
  input  wire intc_pkg::prio_t           cpu_level_value,
  input  wire logic                      delayed_disable_in,
  output logic                           irq_request,
  output logic [$clog2(FLAG_REGS*16)-1:0] irq_vector,
  output intc_pkg::prio_t                irq_priority,
  output intc_pkg::level_t               cpu_level,
  output logic                           alternate_table_select,
  output logic                           nesting_disable
);
  import intc_pkg::*;

  localparam int NUM_SRC  = FLAG_REGS * 16;
  localparam int PRIO_SRC = PRIO_REGS * `SRC_PER_PRIO;
  localparam int VW       = $clog2(NUM_SRC);

  typedef struct packed {
    logic [NUM_SRC-1:0]         flags;
    logic [NUM_SRC-1:0]         enables;
    logic [PRIO_SRC-1:0][2:0]   prio;
    prio_t                      level_low;
    logic                       level_high;
    logic                       nest_dis;
    logic [3:0]                 traps;
    logic                       alt_table;
    logic                       delayed_disable_active;
    logic [`EXT_PINS-1:0]       polarity;
    word_t                      rd_data;
    logic                       irq_req;
    logic [VW-1:0]              irq_vec;
    prio_t                      irq_prio;
  } ctrl_state_t;

  ctrl_state_t          st;
  ctrl_state_t          next_st;
  logic [`EXT_PINS-1:0] ext_pulse;

  ext_edge_detect #(.N(`EXT_PINS)) u_edge (
    .clk        (clk),
    .srst       (srst),
    .pin        (ext_pin),
    .polarity   (st.polarity),
    .edge_pulse (ext_pulse)
  );

  // address map: flags, enables and priority words are banks
  function automatic reg_sel_t decode(input logic [5:0] a);
    if (a == `ADDR_STATUS) return SEL_STATUS;
    if (a == `ADDR_CORE) return SEL_CORE;
    if (a == `ADDR_CTRL1) return SEL_CTRL1;
    if (a == `ADDR_CTRL2) return SEL_CTRL2;
    if (a >= `ADDR_FLAG0 && a < `ADDR_FLAG0 + 6'(FLAG_REGS)) return SEL_FLAG;
    if (a >= `ADDR_ENABLE0 && a < `ADDR_ENABLE0 + 6'(FLAG_REGS)) return SEL_ENABLE;
    if (a >= `ADDR_PRIO0 && a < `ADDR_PRIO0 + 6'(PRIO_REGS) &&
        a != `ADDR_PRIO0 + `PRIO_MISSING) return SEL_PRIO;
    return SEL_NONE;
  endfunction

  function automatic logic [4:0] bank_index(input logic [5:0] a, input reg_sel_t s);
    if (s == SEL_PRIO) return 5'(a - `ADDR_PRIO0);
    if (s == SEL_ENABLE) return 5'(a - `ADDR_ENABLE0);
    return 5'(a - `ADDR_FLAG0);
  endfunction

  // sources without a priority slot stay at level zero
  function automatic prio_t prio_of(input logic [PRIO_SRC-1:0][2:0] p, input int n);
    if (n < PRIO_SRC) return p[n];
    return 3'h0;
  endfunction

  function automatic word_t prio_word(input logic [PRIO_SRC-1:0][2:0] p, input int k);
    word_t w;
    w = `RESET_WORD;
    for (int j = 0; j < `SRC_PER_PRIO; j++) begin
      w[4*j +: 3] = p[`SRC_PER_PRIO*k + j];
    end
    return w;
  endfunction

  always_comb begin
    reg_sel_t           ws;
    reg_sel_t           rs;
    logic [4:0]         wi;
    logic [4:0]         ri;
    logic [NUM_SRC-1:0] set_req;
    level_t             lvl;
    prio_t              best;
    logic [VW-1:0]      best_n;
    logic               found;
    word_t              rv;
    ws = decode(reg_addr);
    rs = ws;
    wi = bank_index(reg_addr, ws);
    ri = wi;
    set_req = src_request;
    lvl = {st.level_high, st.level_low};
    best = 3'h0;
    best_n = '0;
    found = 1'b0;
    rv = `RESET_WORD;
    next_st = st;

    set_req[`EXT0_SRC] = set_req[`EXT0_SRC] | ext_pulse[0];
    set_req[`EXT1_SRC] = set_req[`EXT1_SRC] | ext_pulse[1];
    set_req[`EXT2_SRC] = set_req[`EXT2_SRC] | ext_pulse[2];
    set_req[`EXT3_SRC] = set_req[`EXT3_SRC] | ext_pulse[3];
    set_req[`EXT4_SRC] = set_req[`EXT4_SRC] | ext_pulse[4];

    // register writes; only implemented fields are stored
    if (reg_wr) begin
      unique case (ws)
        SEL_STATUS: begin
          if (!st.nest_dis) begin
            next_st.level_low = reg_wr_data[`LVL_LO_POS +: 3];
          end
        end
        SEL_CORE: begin
          if (!reg_wr_data[`LVL_HI_POS]) begin
            next_st.level_high = 1'b0;
          end
        end
        SEL_CTRL1: begin
          next_st.nest_dis = reg_wr_data[`NEST_POS];
          next_st.traps = reg_wr_data[`TRAP_LSB_POS +: 4];
        end
        SEL_CTRL2: begin
          next_st.alt_table = reg_wr_data[`ALT_POS];
          next_st.polarity = reg_wr_data[`POL_LSB_POS +: `EXT_PINS];
        end
        SEL_FLAG: begin
          next_st.flags[16*wi +: 16] = reg_wr_data;
        end
        SEL_ENABLE: begin
          next_st.enables[16*wi +: 16] = reg_wr_data;
        end
        SEL_PRIO: begin
          for (int j = 0; j < `SRC_PER_PRIO; j++) begin
            next_st.prio[`SRC_PER_PRIO*wi + j] = reg_wr_data[4*j +: 3];
          end
        end
        SEL_NONE: begin
        end
      endcase
    end

    // hardware events win over a clearing write in the same cycle
    next_st.flags = next_st.flags | set_req;
    next_st.traps = next_st.traps |
                    {trap_arith, trap_address, trap_stack, trap_osc};
    if (core_level_set) begin
      next_st.level_high = 1'b1;
    end
    if (cpu_level_load) begin
      next_st.level_low = cpu_level_value;
    end
    next_st.delayed_disable_active = delayed_disable_in;

    // read mux; unused bits stay zero
    unique case (rs)
      SEL_STATUS: rv[`LVL_LO_POS +: 3] = st.level_low;
      SEL_CORE:   rv[`LVL_HI_POS] = st.level_high;
      SEL_CTRL1: begin
        rv[`NEST_POS] = st.nest_dis;
        rv[`TRAP_LSB_POS +: 4] = st.traps;
      end
      SEL_CTRL2: begin
        rv[`ALT_POS] = st.alt_table;
        rv[`DELAYED_DISABLE_ACTIVE_POS] = st.delayed_disable_active;
        rv[`POL_LSB_POS +: `EXT_PINS] = st.polarity;
      end
      SEL_FLAG:   rv = st.flags[16*ri +: 16];
      SEL_ENABLE: rv = st.enables[16*ri +: 16];
      SEL_PRIO:   rv = prio_word(st.prio, int'(ri));
      SEL_NONE:   rv = `RESET_WORD;
    endcase
    next_st.rd_data = reg_rd ? rv : `RESET_WORD;

    // descending scan with >= keeps the lowest vector on ties
    for (int n = NUM_SRC - 1; n >= 0; n--) begin
      if (st.flags[n] && st.enables[n] &&
          ({1'b0, prio_of(st.prio, n)} > lvl) &&
          (!found || prio_of(st.prio, n) >= best)) begin
        found = 1'b1;
        best = prio_of(st.prio, n);
        best_n = VW'(n);
      end
    end
    next_st.irq_req = found;
    next_st.irq_vec = best_n;
    next_st.irq_prio = best;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rd_data = st.rd_data;
  assign irq_request = st.irq_req;
  assign irq_vector = st.irq_vec;
  assign irq_priority = st.irq_prio;
  assign cpu_level = {st.level_high, st.level_low};
  assign alternate_table_select = st.alt_table;
  assign nesting_disable = st.nest_dis;

  // checking helpers
  logic [NUM_SRC-1:0] gate_d;
  always_ff @(posedge clk) begin
    if (srst) begin
      gate_d <= '0;
    end else begin
      gate_d <= st.flags & st.enables;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_ctrl1_rd;
    reg_rd && reg_addr == `ADDR_CTRL1;
  endsequence

  sequence s_ctrl2_rd;
    reg_rd && reg_addr == `ADDR_CTRL2;
  endsequence

  sequence s_core_wr_one;
    reg_wr && reg_addr == `ADDR_CORE && !core_level_set;
  endsequence

  chk_level_seven_block: assert property (
    st.level_low == 3'h7 |=> !irq_request)
    else $error("request issued at cpu level seven");

  chk_high_bit_block: assert property (
    st.level_high |=> !irq_request)
    else $error("request issued while high level bit set");

  chk_high_no_set: assert property (
    s_core_wr_one |=> st.level_high == $past(st.level_high) || !st.level_high)
    else $error("software raised the high level bit");

  chk_nest_lock: assert property (
    reg_wr && reg_addr == `ADDR_STATUS && st.nest_dis && !cpu_level_load
    |=> st.level_low == $past(st.level_low))
    else $error("level bits changed while nesting disabled");

  chk_flag_set_wins: assert property (
    src_request[0] ##0 reg_wr && reg_addr == `ADDR_FLAG0 |=> st.flags[0])
    else $error("source event lost under clearing write");

  chk_ctrl1_unimpl: assert property (
    s_ctrl1_rd |=> reg_rd_data[14:5] == 10'h000 && !reg_rd_data[0] &&
                   reg_rd_data[4:1] == $past(st.traps))
    else $error("control one read back wrong");

  chk_ctrl2_status: assert property (
    s_ctrl2_rd |=> reg_rd_data[13:5] == 9'h000 &&
                   reg_rd_data[14] == $past(delayed_disable_in, 2))
    else $error("delayed disable status not mirrored");

  chk_enable_gate: assert property (
    irq_request |-> gate_d[irq_vector])
    else $error("request for a disabled or idle source");

  chk_above_level: assert property (
    irq_request |-> {1'b0, irq_priority} > $past(cpu_level))
    else $error("request not above cpu level");

  chk_ext_edge_flag: assert property (
    ext_pulse[0] |=> st.flags[`EXT0_SRC])
    else $error("external edge did not set its flag");

  chk_alt_follow: assert property (
    reg_wr && reg_addr == `ADDR_CTRL2
    |=> alternate_table_select == $past(reg_wr_data[`ALT_POS]))
    else $error("alternate table select not written");

  chk_read_idle_zero: assert property (
    !reg_rd |=> reg_rd_data == `RESET_WORD)
    else $error("read data not zero outside a read");

  chk_unmapped_read: assert property (
    reg_rd && decode(reg_addr) == SEL_NONE |=> reg_rd_data == `RESET_WORD)
    else $error("unmapped address read back nonzero");

  chk_delayed_disable_active_read_only: assert property (
    reg_wr && reg_addr == `ADDR_CTRL2 |=> st.delayed_disable_active == $past(delayed_disable_in))
    else $error("delayed disable status changed by a write");

  chk_level_high_set: assert property (
    core_level_set |=> st.level_high)
    else $error("trap entry did not raise the high level bit");
endmodule
`default_nettype wire

// ### verification/cpu_side_model.sv
// cpu core and request source model facing the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
  input  wire logic            clk,
  input  wire logic            irq_request,
  input  wire intc_pkg::prio_t irq_priority,
  output logic [79:0]          src_request,
  output logic [3:0]           trap,
  output logic                 core_level_set,
  output logic                 cpu_level_load,
  output intc_pkg::prio_t      cpu_level_value
);
  import intc_pkg::*;
  logic accept;

  initial begin
    src_request = '0;
    trap = '0;
    core_level_set = 1'b0;
    cpu_level_load = 1'b0;
    cpu_level_value = '0;
    accept = 1'b0;
  end

  // taking an interrupt raises the level to the winner's priority
  always @(posedge clk) begin
    cpu_level_load <= accept && irq_request && !cpu_level_load;
    cpu_level_value <= irq_priority;
  end

  // one-cycle event pulses from peripherals, traps and trap entry
  task pulse(input logic [79:0] m, input logic [3:0] t, input logic c);
    @(posedge clk);
    src_request <= m;
    trap <= t;
    core_level_set <= c;
    @(posedge clk);
    src_request <= '0;
    trap <= '0;
    core_level_set <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/interrupt_priority_control_test.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_control_test;
  import intc_pkg::*;
  logic        clk;
  logic        srst;
  logic [5:0]  reg_addr;
  word_t       reg_wr_data;
  logic        reg_wr;
  logic        reg_rd;
  word_t       reg_rd_data;
  logic [79:0] src_request;
  logic [4:0]  ext_pin;
  logic [3:0]  trap;
  logic        core_level_set;
  logic        cpu_level_load;
  prio_t       cpu_level_value;
  logic        ddis;
  logic        irq_request;
  logic [6:0]  irq_vector;
  prio_t       irq_priority;
  level_t      cpu_level;
  logic        alternate_table_select;
  logic        nesting_disable;
  int          fails;
  int          compares;

  interrupt_priority_control uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .src_request(src_request), .ext_pin(ext_pin), .trap_arith(trap[3]),
    .trap_address(trap[2]), .trap_stack(trap[1]), .trap_osc(trap[0]),
    .core_level_set(core_level_set), .cpu_level_load(cpu_level_load),
    .cpu_level_value(cpu_level_value), .delayed_disable_in(ddis),
    .irq_request(irq_request), .irq_vector(irq_vector),
    .irq_priority(irq_priority), .cpu_level(cpu_level),
    .alternate_table_select(alternate_table_select),
    .nesting_disable(nesting_disable)
  );

  cpu_side_model pm (
    .clk(clk), .irq_request(irq_request), .irq_priority(irq_priority),
    .src_request(src_request), .trap(trap), .core_level_set(core_level_set),
    .cpu_level_load(cpu_level_load), .cpu_level_value(cpu_level_value)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input word_t got, input word_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [5:0] a, input word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [5:0] a, input word_t exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rd_data, exp);
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // request output two cycles after the cause settles
  task irq(input logic r, input logic [6:0] v, input prio_t p);
    step(2);
    chk({15'h0, irq_request}, {15'h0, r});
    if (r) begin
      chk({9'h0, irq_vector}, {9'h0, v});
      chk({13'h0, irq_priority}, {13'h0, p});
    end
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    results;
  end

  initial begin
    srst = 1'b1;
    reg_addr = '0;
    reg_wr_data = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_pin = '0;
    ddis = 1'b0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(6'h02, 16'h0000);
    rd(6'h03, 16'h0000);
    rd(6'h00, 16'h0000);
    wr(6'h02, 16'hffff);
    rd(6'h02, 16'h801e);
    chk({15'h0, nesting_disable}, 16'h0001);
    wr(6'h00, 16'h00e0);
    rd(6'h00, 16'h0000);
    wr(6'h02, 16'h0000);
    pm.pulse('0, 4'h9, 1'b0);
    rd(6'h02, 16'h0012);
    wr(6'h02, 16'h0000);
    wr(6'h03, 16'hffff);
    rd(6'h03, 16'h801f);
    chk({15'h0, alternate_table_select}, 16'h0001);
    @(posedge clk);
    ddis <= 1'b1;
    step(3);
    rd(6'h03, 16'hc01f);
    ddis <= 1'b0;
    wr(6'h03, 16'h0000);
    wr(6'h2f, 16'hffff);
    rd(6'h2f, 16'h0000);
    wr(6'h30, 16'h7777);
    rd(6'h30, 16'h7777);
    wr(6'h00, 16'h00a0);
    rd(6'h00, 16'h00a0);
    chk({12'h0, cpu_level}, 16'h0005);
    wr(6'h01, 16'h0008);
    rd(6'h01, 16'h0000);
    pm.pulse('0, 4'h0, 1'b1);
    rd(6'h01, 16'h0008);
    chk({12'h0, cpu_level}, 16'h000d);
    wr(6'h01, 16'h0000);
    wr(6'h00, 16'h0040);
    wr(6'h21, 16'h0330);
    wr(6'h10, 16'h0060);
    pm.pulse(80'h60, 4'h0, 1'b0);
    rd(6'h08, 16'h0060);
    irq(1'b1, 7'd5, 3'd3);
    wr(6'h21, 16'h0430);
    irq(1'b1, 7'd6, 3'd4);
    wr(6'h00, 16'h0080);
    irq(1'b0, 7'd0, 3'd0);
    wr(6'h00, 16'h0060);
    irq(1'b1, 7'd6, 3'd4);
    wr(6'h10, 16'h0000);
    irq(1'b0, 7'd0, 3'd0);
    wr(6'h10, 16'h0060);
    wr(6'h08, 16'h0000);
    rd(6'h08, 16'h0000);
    irq(1'b0, 7'd0, 3'd0);
    wr(6'h21, 16'h0700);
    wr(6'h00, 16'h00e0);
    pm.pulse(80'h40, 4'h0, 1'b0);
    irq(1'b0, 7'd0, 3'd0);
    wr(6'h00, 16'h0000);
    irq(1'b1, 7'd6, 3'd7);
    pm.pulse('0, 4'h0, 1'b1);
    irq(1'b0, 7'd0, 3'd0);
    wr(6'h01, 16'h0000);
    irq(1'b1, 7'd6, 3'd7);
    pm.accept = 1'b1;
    step(4);
    chk({12'h0, cpu_level}, 16'h0007);
    pm.accept = 1'b0;
    wr(6'h08, 16'h0000);
    wr(6'h03, 16'h0002);
    @(posedge clk);
    ext_pin <= 5'h03;
    step(8);
    rd(6'h08, 16'h0001);
    rd(6'h09, 16'h0000);
    @(posedge clk);
    ext_pin <= 5'h00;
    step(8);
    rd(6'h09, 16'h0010);
    fork
      pm.pulse(80'h1, 4'h0, 1'b0);
      wr(6'h08, 16'h0000);
    join
    rd(6'h08, 16'h0001);
    results;
  end
endmodule
`default_nettype wire
